// ---- rtl/tpc_pkg.sv ----
// shared constants for the timer match, capture and control slice
package tpc_pkg;
	localparam int unsigned NT     = 2;  // timers in the slice
	localparam int unsigned ADDR_W = 14; // byte address width on the bus

	// register indices; the byte address is four times the index
	localparam logic [11:0] IDX_MATCH_HI [NT] = '{12'hf04, 12'hf0c};
	localparam logic [11:0] IDX_MATCH_LO [NT] = '{12'hf05, 12'hf0d};
	localparam logic [11:0] IDX_CTL0     [NT] = '{12'hf06, 12'hf0e};
	localparam logic [11:0] IDX_INT_STAT      = 12'hf14;
	localparam logic [11:0] IDX_INT_MASK      = 12'hf15;

	// reset values
	localparam logic [7:0]  MATCH_RESET = 8'h00;
	localparam logic [7:0]  CTL0_RESET  = 8'h00;

	// control register zero field positions
	localparam int          MSB_BIT  = 7; // mode select msb
	localparam int          ICFG_MSB = 6; // interrupt source select
	localparam int          ICFG_LSB = 5;
	localparam int          DB_MSB   = 3; // deadband delay select
	localparam int          DB_LSB   = 1;
	localparam int          CAPF_BIT = 0; // capture event flag

	// interrupt source select codes; 0x means every event
	localparam logic [1:0]  ICFG_CAP_ONLY = 2'h2;
	localparam logic [1:0]  ICFG_RLD_ONLY = 2'h3;

	// full mode values that make the match bytes a capture store;
	// they must agree with the mode decoder that lives elsewhere
	localparam logic [3:0]  MODE_CAPTURE = 4'h4;
	localparam logic [3:0]  MODE_CAPCMP  = 4'h7;

	// deadband delay for a nonzero code is this unit shifted left by the code
	localparam logic [7:0]  DB_UNIT = 8'h01;

	// htrans bit that marks nonseq or seq
	localparam int          HTRANS_ACT_BIT = 1;

	// bus slave phases
	typedef enum logic {BUS_IDLE, BUS_DATA} tpc_bus_t;
endpackage

// ---- rtl/tpc_match.sv ----
// per-timer compare of count against match value and output phase
`timescale 1ns/1ps
module tpc_match
#(
	parameter int CW = 16 // counter width
)
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic [CW-1:0] count,     // running timer count
	input  wire logic [CW-1:0] match,     // high and low match bytes
	input  wire logic          enable,    // timer enabled
	input  wire logic          reload,    // counter reloaded this cycle
	output logic               phase_r,   // primary output active
	output logic               cmp_evt_r  // one-cycle pulse on new match
);
	logic eq_w;   // count equals match this cycle
	logic eq_q_r; // equality one cycle ago

	// compare runs every cycle, no sampling window
	assign eq_w = (count == match);

	// edge detect so a count parked on the match fires once
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			eq_q_r    <= 1'b0;
			cmp_evt_r <= 1'b0;
		end
		else
		begin
			eq_q_r    <= eq_w;
			cmp_evt_r <= eq_w && !eq_q_r && enable;
		end
	end

	// phase: set on match, cleared on reload; reload wins since the
	// count is restarting and a late match would stretch the pulse
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			phase_r <= 1'b0;
		else if (!enable)
			phase_r <= 1'b0;  // idle level is the polarity bit
		else if (reload)
			phase_r <= 1'b0;
		else if (eq_w)
			phase_r <= 1'b1;
	end
endmodule

// ---- rtl/tpc_dead.sv ----
// deadband delay between an output and its complement going active
`timescale 1ns/1ps
module tpc_dead
	import tpc_pkg::*;
#(
	parameter int DW = 3 // delay code width
)
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          phase,  // requested side: 1 primary
	input  wire logic [DW-1:0] code,   // deadband delay select
	output logic               act_p,  // primary active
	output logic               act_n   // complement active
);
	logic [7:0] dly_w;   // delay in cycles for the code
	logic [7:0] cnt_r;   // cycles left before the new side goes on
	logic       phase_q; // phase already acted on

	// code 0 is no delay, others are two to the code
	assign dly_w = (code == '0) ? 8'h00 : 8'(DB_UNIT << code);

	// with a nonzero code both sides drop at once on a change, the new side waits;
	// a change in mid-wait restarts the wait for the latest phase
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_q <= 1'b0;
			cnt_r   <= 8'h00;
			act_p   <= 1'b0;
			act_n   <= 1'b0;
		end
		else if (phase != phase_q)
		begin
			phase_q <= phase;
			act_p   <= (dly_w == 8'h00) && phase;
			act_n   <= (dly_w == 8'h00) && !phase;
			cnt_r   <= (dly_w == 8'h00) ? 8'h00 : dly_w - 8'h01;
		end
		else if (cnt_r != 8'h00)
			cnt_r <= cnt_r - 8'h01;
		else
		begin
			act_p <= phase_q;
			act_n <= !phase_q;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// a change with code 1 keeps both sides off, then turns one on
	sequence s_step;
		$changed(phase) && code == 3'h1
		##1 $stable(phase) && code == 3'h1
		##1 $stable(phase) && code == 3'h1;
	endsequence

	// the side that comes on is the one requested before this cycle
	dead_gap_a: assert property (s_step |-> !act_p && !act_n
		##1 act_p == $past(phase) && act_n == !$past(phase))
		else $error("deadband gap wrong for code one");
endmodule

// ---- rtl/tpc_top.sv ----
// timer match, capture and control-zero register slice on ahb-lite
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
//
// Behaviour
// - match value compared with count continuously
// - equal count changes the pwm output state
// - polarity bit sets the driven output level
// - high byte bits 15:8, low 7:0
// - capture modes store count into match bytes
// - match bytes at fixed offsets, reset zero
// - control registers are 8-bit read/write
// - mode chosen by control zero and one
// - control zero holds pwm deadband delay
// - two-bit field selects interrupt sources
// - flag marks capture-caused last interrupt
// - control zero offsets, reset, bit layout
// - 0x all, 10 capture, 11 reload/compare
// - deadband zero or two to code cycles
// - mode msb tops the control-one mode bits
module tpc_top
	import tpc_pkg::*;
#(
	parameter int CW = 16, // counter width
	parameter int DW = 3   // deadband code width
)
(
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   hsel,
	input  wire logic [ADDR_W-1:0]      haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic      [31:0]            hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	input  wire logic [NT-1:0][CW-1:0]  tmr_count,
	input  wire logic [NT-1:0][2:0]     mode_select_low_field,
	input  wire logic [NT-1:0]          output_polarity_bit,
	input  wire logic [NT-1:0]          tmr_enable,
	input  wire logic [NT-1:0]          reload_evt,
	input  wire logic [NT-1:0]          capture_evt,
	output logic      [NT-1:0]          pwm_out,
	output logic      [NT-1:0]          pwm_out_comp,
	output logic      [NT-1:0][3:0]     mode_value,
	output logic      [NT-1:0]          timer_int,
	output logic                        irq
);
	// register file
	logic [7:0]    match_hi_r [NT]; // match value high bytes
	logic [7:0]    match_lo_r [NT]; // match value low bytes
	logic [7:0]    ctl0_r     [NT]; // control register zero
	logic [NT-1:0] int_stat_r;      // sticky timer interrupt bits
	logic [NT-1:0] int_stat_nxt;    // next sticky bits
	logic [NT-1:0] int_mask_r;      // interrupt enables

	// bus slave state
	tpc_bus_t      bus_st_r;        // address or data phase
	logic [11:0]   idx_r;           // latched word index
	logic          wr_r;            // latched direction
	logic          acc_w;           // address phase taken
	logic          wr_go_w;         // write lands this cycle
	logic          rd_go_w;         // read data loads this cycle
	logic [7:0]    rd_mux;          // selected register byte

	// per-timer event wires
	logic [NT-1:0] eq_w;            // count equals match
	logic [NT-1:0] cap_ev_w;        // capture stores this cycle
	logic [NT-1:0] rc_ev_w;         // reload or compare event
	logic [NT-1:0] int_ev_w;        // timer interrupt after filter
	logic [NT-1:0] cap_int_w;       // interrupt counts a capture
	logic [NT-1:0] cmp_evt_w;       // compare pulse from matcher
	logic [NT-1:0] phase_w;         // requested output phase
	logic [NT-1:0] act_p_w;         // primary side active
	logic [NT-1:0] act_n_w;         // complement side active
	logic [NT-1:0][3:0] mode_w;     // full mode value

	// an address phase is only taken while the bus is ready
	assign acc_w   = hsel && htrans[HTRANS_ACT_BIT] && hready;
	assign wr_go_w = (bus_st_r == BUS_DATA) && wr_r;
	assign rd_go_w = (bus_st_r == BUS_DATA) && !wr_r;

	// every transfer gets one wait state; the write lands in it, so a
	// read straight after a write always sees the new value
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			bus_st_r  <= BUS_IDLE;
			idx_r     <= 12'h000;
			wr_r      <= 1'b0;
			hreadyout <= 1'b1;
		end
		else
		begin
			case (bus_st_r)
				BUS_IDLE:
				begin
					if (acc_w)
					begin
						idx_r     <= haddr[ADDR_W-1:2];
						wr_r      <= hwrite;
						hreadyout <= 1'b0;
						bus_st_r  <= BUS_DATA;
					end
				end
				BUS_DATA:
				begin
					hreadyout <= 1'b1;
					bus_st_r  <= BUS_IDLE;
				end
				default:
				begin
					hreadyout <= 1'b1;
					bus_st_r  <= BUS_IDLE;
				end
			endcase
		end
	end

	// the slave never errors; unmapped reads give zero
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	// read select; match and control registers are 8-bit, status and mask NT-bit, upper bits zero
	always_comb
	begin
		rd_mux = 8'h00;
		for (int i = 0; i < NT; i++)
		begin
			if (idx_r == IDX_MATCH_HI[i])
				rd_mux = match_hi_r[i];
			if (idx_r == IDX_MATCH_LO[i])
				rd_mux = match_lo_r[i];
			if (idx_r == IDX_CTL0[i])
				rd_mux = ctl0_r[i];
		end
		if (idx_r == IDX_INT_STAT)
			rd_mux = 8'(int_stat_r);
		if (idx_r == IDX_INT_MASK)
			rd_mux = 8'(int_mask_r);
	end

	// read data is held until the next read
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (rd_go_w)
			hrdata <= {24'h000000, rd_mux};
	end

	// per-timer decode, compare and deadband
	for (genvar t = 0; t < NT; t++)
	begin : g_tmr
		logic [1:0] icfg_w; // interrupt source select

		// msb from control zero over the control-one mode bits
		assign mode_w[t] = {ctl0_r[t][MSB_BIT], mode_select_low_field[t]};
		assign icfg_w    = ctl0_r[t][ICFG_MSB:ICFG_LSB];

		// match value is high byte over low byte
		assign eq_w[t] = (tmr_count[t] == {match_hi_r[t], match_lo_r[t]});

		// capture only stores in the two capture modes
		assign cap_ev_w[t] = capture_evt[t] &&
			(mode_w[t] == MODE_CAPTURE || mode_w[t] == MODE_CAPCMP);
		assign rc_ev_w[t]  = reload_evt[t] || cmp_evt_w[t];

		// interrupt filter by source select
		assign cap_int_w[t] = cap_ev_w[t] && (icfg_w != ICFG_RLD_ONLY);
		assign int_ev_w[t]  = !icfg_w[1] ? (cap_ev_w[t] || rc_ev_w[t]) :
			(icfg_w == ICFG_CAP_ONLY) ? cap_ev_w[t] : rc_ev_w[t];

		tpc_match #(
			.CW        (CW)
		) u_match (
			.clk       (hclk),
			.rst_n     (hresetn),
			.count     (tmr_count[t]),
			.match     ({match_hi_r[t], match_lo_r[t]}),
			.enable    (tmr_enable[t]),
			.reload    (reload_evt[t]),
			.phase_r   (phase_w[t]),
			.cmp_evt_r (cmp_evt_w[t])
		);

		tpc_dead #(
			.DW    (DW)
		) u_dead (
			.clk   (hclk),
			.rst_n (hresetn),
			.phase (phase_w[t]),
			.code  (ctl0_r[t][DB_MSB:DB_LSB]),
			.act_p (act_p_w[t]),
			.act_n (act_n_w[t])
		);
	end

	// match bytes: capture beats a software write in the same cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < NT; i++)
			begin
				match_hi_r[i] <= MATCH_RESET;
				match_lo_r[i] <= MATCH_RESET;
			end
		end
		else
		begin
			for (int i = 0; i < NT; i++)
			begin
				if (cap_ev_w[i])
					{match_hi_r[i], match_lo_r[i]} <= tmr_count[i];
				else if (wr_go_w && idx_r == IDX_MATCH_HI[i])
					match_hi_r[i] <= hwdata[7:0];
				else if (wr_go_w && idx_r == IDX_MATCH_LO[i])
					match_lo_r[i] <= hwdata[7:0];
			end
		end
	end

	// control zero; the reserved bit is stored as written, so it only
	// stays zero if software keeps to that; the flag is set by hardware
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < NT; i++)
				ctl0_r[i] <= CTL0_RESET;
		end
		else
		begin
			for (int i = 0; i < NT; i++)
			begin
				if (wr_go_w && idx_r == IDX_CTL0[i])
					ctl0_r[i] <= hwdata[7:0];
				if (int_ev_w[i])
					ctl0_r[i][CAPF_BIT] <= cap_int_w[i];
			end
		end
	end

	// sticky status: a read clears, a same-cycle event still sets
	assign int_stat_nxt = (rd_go_w && idx_r == IDX_INT_STAT ? '0 : int_stat_r) | int_ev_w;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			int_stat_r <= '0;
			int_mask_r <= '0;
			irq        <= 1'b0;
		end
		else
		begin
			int_stat_r <= int_stat_nxt;
			irq        <= |(int_stat_nxt & int_mask_r);
			if (wr_go_w && idx_r == IDX_INT_MASK)
				int_mask_r <= hwdata[NT-1:0];
		end
	end

	// output pins: polarity gives the idle level, phase flips it
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pwm_out      <= '0;
			pwm_out_comp <= '0;
			mode_value   <= '0;
			timer_int    <= '0;
		end
		else
		begin
			pwm_out      <= output_polarity_bit ^ act_p_w;
			pwm_out_comp <= output_polarity_bit ^ act_n_w;
			mode_value   <= mode_w;
			timer_int    <= int_ev_w;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// address phase taken from idle
	sequence s_addr;
		acc_w && bus_st_r == BUS_IDLE;
	endsequence

	bus_wait_a: assert property (s_addr |=> !hreadyout ##1 hreadyout)
		else $error("bus wait state missing");

	stat_clear_a: assert property (rd_go_w && idx_r == IDX_INT_STAT && int_ev_w == '0
		|=> int_stat_r == '0)
		else $error("status not cleared by read");

	stat_set_a: assert property (int_ev_w != '0
		|=> (int_stat_r & $past(int_ev_w)) == $past(int_ev_w))
		else $error("interrupt event lost");

	irq_level_a: assert property ($stable(int_mask_r) |-> irq == |(int_stat_r & int_mask_r))
		else $error("irq level disagrees with status");

	for (genvar t = 0; t < NT; t++)
	begin : g_chk
		// timer running, no reload, no deadband, polarity steady
		sequence s_quiet;
			tmr_enable[t] && !reload_evt[t] && $stable(output_polarity_bit[t])
				&& ctl0_r[t][DB_MSB:DB_LSB] == 3'h0;
		endsequence

		cmp_pulse_a: assert property ($rose(eq_w[t]) && tmr_enable[t] |=> cmp_evt_w[t])
			else $error("compare pulse missing");

		pwm_match_a: assert property ($rose(eq_w[t]) ##0 s_quiet ##1 s_quiet ##1 s_quiet
			|=> pwm_out[t] == !$past(output_polarity_bit[t]))
			else $error("pwm output did not change on match");

		pol_idle_a: assert property ((!tmr_enable[t] && $stable(output_polarity_bit[t]))[*3]
			|=> pwm_out[t] == $past(output_polarity_bit[t]))
			else $error("idle output not at polarity");

		cap_load_a: assert property (cap_ev_w[t]
			|=> {match_hi_r[t], match_lo_r[t]} == $past(tmr_count[t]))
			else $error("capture not stored coherently");

		hi_write_a: assert property (wr_go_w && idx_r == IDX_MATCH_HI[t] && !cap_ev_w[t]
			|=> match_hi_r[t] == $past(hwdata[7:0]))
			else $error("match high byte write lost");

		ctl_write_a: assert property (wr_go_w && idx_r == IDX_CTL0[t] && !int_ev_w[t]
			|=> ctl0_r[t] == $past(hwdata[7:0]))
			else $error("control zero write lost");

		cap_flag_a: assert property (int_ev_w[t]
			|=> ctl0_r[t][CAPF_BIT] == $past(cap_int_w[t]))
			else $error("capture flag wrong after interrupt");

		int_only_a: assert property (ctl0_r[t][ICFG_MSB:ICFG_LSB] == ICFG_CAP_ONLY
			&& !cap_ev_w[t] |=> !timer_int[t])
			else $error("filtered interrupt raised");
	end
endmodule

// ---- testbench/tpc_pin_load.sv ----
// behavioural load on one timer output pin pair
`timescale 1ns/1ps
module tpc_pin_load
(
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic pin,          // timer output
	input  wire logic pin_comp,     // timer output complement
	input  wire logic pol,          // inactive level of both pins
	output logic      overlap_seen  // both pins were active together
);
	// a bridge driven from both pins shorts if they are active at once;
	// the flag is sticky so a single bad cycle is not lost
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			overlap_seen <= 1'b0;
		else if (pin != pol && pin_comp != pol)
			overlap_seen <= 1'b1;
	end
endmodule

// ---- testbench/testbench.sv ----
// register, compare, capture and interrupt tests of the timer slice
`timescale 1ns/1ps
module testbench;
	import tpc_pkg::*;
	logic                  hclk, hresetn, hsel, hwrite;
	logic [ADDR_W-1:0]     haddr;
	logic [1:0]            htrans;
	logic [31:0]           hwdata, hrdata;
	logic                  hreadyout, hresp, irq, overlap_seen;
	logic [NT-1:0][15:0]   tmr_count;
	logic [NT-1:0][2:0]    mode_low;
	logic [NT-1:0]         pol, tmr_enable, reload_evt, capture_evt;
	logic [NT-1:0]         pwm_out, pwm_out_comp, timer_int;
	logic [NT-1:0][3:0]    mode_value;
	int                    num_errors, checks;
	logic                  expv;

	tpc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.tmr_count(tmr_count), .mode_select_low_field(mode_low),
		.output_polarity_bit(pol), .tmr_enable(tmr_enable), .reload_evt(reload_evt),
		.capture_evt(capture_evt), .pwm_out(pwm_out), .pwm_out_comp(pwm_out_comp),
		.mode_value(mode_value), .timer_int(timer_int), .irq(irq));

	tpc_pin_load load_u (.hclk(hclk), .hresetn(hresetn), .pin(pwm_out[0]),
		.pin_comp(pwm_out_comp[0]), .pol(pol[0]), .overlap_seen(overlap_seen));

	// 10 MHz clock
	initial
	begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	// single verdict point
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// compare seen against expected, four-state exact
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one ahb-lite single transfer; waits on hready without assuming latency,
	// only the watchdog ends a wait that never finishes
	task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] d,
		output logic [31:0] q);
		hsel   <= 1'b1;
		haddr  <= {idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [11:0] idx, input logic [7:0] v);
		logic [31:0] q;
		bus(1'b1, idx, {24'h0, v}, q);
	endtask

	task automatic rd(input string what, input logic [11:0] idx, input logic [7:0] v);
		logic [31:0] q;
		bus(1'b0, idx, 32'h0, q);
		chk(what, q, {24'h0, v});
		chk("hresp okay", {31'h0, hresp}, 32'h0);
	endtask

	// one-cycle timer event on timer 0: capture or reload
	task automatic evt(input logic cap);
		if (cap)
			capture_evt <= 2'b01;
		else
			reload_evt <= 2'b01;
		@(posedge hclk);
		capture_evt <= 2'b00;
		reload_evt  <= 2'b00;
		@(posedge hclk);
	endtask

	// hang guard, well beyond the few hundred cycles of the tests
	initial
	begin
		repeat (20000) @(posedge hclk);
		num_errors++;
		tally_and_finish();
	end

	initial
	begin
		hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
		hwdata = '0; tmr_count = '0; mode_low = '0; pol = '0; tmr_enable = '0;
		reload_evt = '0; capture_evt = '0; num_errors = 0; checks = 0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset values, then full-byte write and readback
		for (int t = 0; t < NT; t++)
		begin
			rd("match_hi rst", IDX_MATCH_HI[t], MATCH_RESET);
			rd("match_lo rst", IDX_MATCH_LO[t], MATCH_RESET);
			rd("ctl0 rst", IDX_CTL0[t], CTL0_RESET);
			wr(IDX_MATCH_HI[t], 8'h5a);
			wr(IDX_MATCH_LO[t], 8'hc3);
			wr(IDX_CTL0[t], 8'hee); // reserved bit kept zero
			rd("match_hi rw", IDX_MATCH_HI[t], 8'h5a);
			rd("match_lo rw", IDX_MATCH_LO[t], 8'hc3);
			rd("ctl0 rw", IDX_CTL0[t], 8'hee);
		end
		rd("unmapped", 12'hf10, 8'h00);
		// mode value joins the control-zero msb with control-one bits
		mode_low <= {3'b101, 3'b101};
		repeat (2) @(posedge hclk);
		chk("mode t0", {28'h0, mode_value[0]}, 32'hd);
		chk("mode t1", {28'h0, mode_value[1]}, 32'hd);
		mode_low <= '0;
		// compare at match 0x0010, both polarities, deadband zero
		wr(IDX_CTL0[0], 8'h00);
		wr(IDX_MATCH_HI[0], 8'h00);
		wr(IDX_MATCH_LO[0], 8'h10);
		tmr_count[0] <= 16'h0005;
		tmr_enable[0] <= 1'b1;
		for (int p = 0; p < 2; p++)
		begin
			pol[0] <= p[0];
			evt(1'b0);
			repeat (12) @(posedge hclk);
			chk("out idle", {31'h0, pwm_out[0]}, {31'h0, p[0]});
			chk("comp idle", {31'h0, pwm_out_comp[0]}, {31'h0, ~p[0]});
			tmr_count[0] <= 16'h0010;
			repeat (4) @(posedge hclk);
			chk("out match", {31'h0, pwm_out[0]}, {31'h0, ~p[0]});
			chk("comp match", {31'h0, pwm_out_comp[0]}, {31'h0, p[0]});
			tmr_count[0] <= 16'h0005;
		end
		// low byte alone must not match: only the full 16 bits compare
		evt(1'b0);
		repeat (12) @(posedge hclk);
		tmr_count[0] <= 16'h0110;
		repeat (6) @(posedge hclk);
		chk("no part match", {31'h0, pwm_out[0]}, 32'h1);
		// deadband code 2 holds the active side off for 4 more cycles
		wr(IDX_CTL0[0], 8'h04);
		tmr_count[0] <= 16'h0005;
		evt(1'b0);
		repeat (12) @(posedge hclk);
		tmr_count[0] <= 16'h0010;
		repeat (7) @(posedge hclk);
		chk("db hold", {31'h0, pwm_out[0]}, 32'h1);
		@(posedge hclk);
		chk("db active", {31'h0, pwm_out[0]}, 32'h0);
		// code 1 delays the rising phase by two cycles; the falling phase is only checked for overlap
		wr(IDX_CTL0[0], 8'h02);
		tmr_count[0] <= 16'h0005;
		evt(1'b0);
		repeat (4) @(posedge hclk);
		tmr_count[0] <= 16'h0010;
		repeat (5) @(posedge hclk);
		chk("db1 hold", {31'h0, pwm_out[0]}, 32'h1);
		@(posedge hclk);
		chk("db1 active", {31'h0, pwm_out[0]}, 32'h0);
		chk("no overlap", {31'h0, overlap_seen}, 32'h0);
		tmr_enable[0] <= 1'b0;
		// interrupt source select against both event kinds, capture mode
		mode_low[0] <= 3'b100;
		tmr_count[0] <= 16'hbeef;
		wr(IDX_INT_MASK, 8'h01);
		rd("stat clr", IDX_INT_STAT, 8'h01);
		for (int ic = 0; ic < 4; ic++)
			for (int e = 0; e < 2; e++)
			begin
				wr(IDX_CTL0[0], {1'b0, ic[1:0], 5'h0});
				expv = (ic < 2) || (ic == 2 && e == 0) || (ic == 3 && e == 1);
				evt(e == 0);
				chk("tmr int", {31'h0, timer_int[0]}, {31'h0, expv});
				@(posedge hclk);
				chk("irq on", {31'h0, irq}, {31'h0, expv});
				if (ic == 0)
					rd("cap flag", IDX_CTL0[0], {7'h0, e == 0});
				rd("stat", IDX_INT_STAT, {7'h0, expv});
				repeat (2) @(posedge hclk);
				chk("irq off", {31'h0, irq}, 32'h0);
			end
		rd("cap hi", IDX_MATCH_HI[0], 8'hbe);
		rd("cap lo", IDX_MATCH_LO[0], 8'hef);
		// capture outside capture modes leaves the match bytes alone
		mode_low[0] <= 3'b000;
		tmr_count[0] <= 16'h1234;
		evt(1'b1);
		rd("no cap", IDX_MATCH_HI[0], 8'hbe);
		// masked event sets status but keeps irq low
		wr(IDX_INT_MASK, 8'h00);
		evt(1'b0);
		@(posedge hclk);
		chk("irq masked", {31'h0, irq}, 32'h0);
		rd("stat masked", IDX_INT_STAT, 8'h01);
		tally_and_finish();
	end
endmodule
